// [rtl/acc_pkg.sv]
// How it works
// - clock field: 0x external pin, 10 oscillator, 11 oscillator plus pin out
// - full shutdown stops master clock ticks everywhere
// - clock field change restarts conversion, setup timer, phases
// - oscillator free runs, stops only when upper clock bit clear
// - oscillator keeps running in converter shutdown
// - field 11 drives prescaled clock on pin right after write
// - result is (raw plus offset) times gain
// - a disabled correction is skipped, its register ignored
// - guard bits; saturate only the final result
// - offset is 24-bit signed two's complement
// - offset add is plain, no pipeline delay
// - offset changes apply from the next result only
// - gain is 24-bit unsigned, code over 8388608
// - shift-add gain on modulator clock, 23 ticks of delay
// - gain changes apply from the next result only
// - mode 0x: one conversion then shutdown, state back to 00
// - mode 10: one conversion then standby, state 10
// - mode 11: convert continuously, state stays 11
// - state 11 converts only once setup timer reaches zero
`default_nettype none
package acc_pkg;
	// ----------------------------------------
	// register map and fields
	// ----------------------------------------
	localparam logic [3:0] ADR_RESULT = 4'h0;
	localparam logic [3:0] ADR_CFG0 = 4'h1;
	localparam logic [3:0] ADR_CFG1 = 4'h2;
	localparam logic [3:0] ADR_CFG3 = 4'h4;
	localparam logic [3:0] ADR_OFFSET = 4'h9;
	localparam logic [3:0] ADR_GAIN = 4'hA;
	localparam int CLK_LSB = 4;
	localparam int MODE_LSB = 0;
	localparam int PRE_LSB = 6;
	localparam int CONV_LSB = 6;
	localparam int OFFEN_BIT = 1;
	localparam int GAINEN_BIT = 0;
	localparam logic [7:0] CFG0_RST = 8'hC0;
	localparam logic [7:0] CFG1_RST = 8'h00;
	localparam logic [7:0] CFG3_RST = 8'h00;
	localparam logic [23:0] GAIN_RST = 24'h800000;
	// ----------------------------------------
	// counts
	// ----------------------------------------
	localparam logic [8:0] SETUP_TICKS = 9'h100;
	localparam logic [4:0] GAIN_STEPS = 5'h17;
	localparam int GAIN_FRAC = 23;
	localparam logic [1:0] DM_DIV_MAX = 2'h3;
	localparam logic signed [49:0] RES_MAX = 50'sh00000007FFFFF;
	localparam logic signed [49:0] RES_MIN = -50'sh0000000800000;
	typedef logic signed [49:0] acc_wide_t;
	typedef enum logic {GP_IDLE, GP_RUN} acc_gp_e;
	typedef struct packed {
		logic [7:0] cfg0;
		logic [7:0] cfg1;
		logic [7:0] cfg3;
		logic [23:0] off;
		logic [23:0] gain;
		logic [23:0] result;
		logic [23:0] rdata;
		logic ext1;
		logic ext2;
		logic ext3;
		logic [7:0] osc_cnt;
		logic [2:0] pre_cnt;
		logic [1:0] dm_cnt;
		logic divided_clock_out;
		logic oe;
		logic osc_en;
		logic mclk_en;
		logic dm_pulse;
		logic [8:0] timer;
		acc_gp_e gstate;
		logic [4:0] gidx;
		logic [23:0] gmul;
		acc_wide_t gx;
		acc_wide_t gacc;
		logic pend;
		logic drdy;
		logic restart;
		logic run;
	} acc_state_s;
endpackage
`default_nettype wire

// [rtl/acc_ctrl.sv]
`default_nettype none
module acc_ctrl #(
	parameter logic [7:0] OSC_DIV = 8'h28 // ref cycles per osc tick
) (
	input wire logic REF_CLK, // 200 MHz
	input wire logic RESET, // sync, active high
	input wire logic REG_WR, // register write strobe
	input wire logic REG_RD, // register read strobe
	input wire logic [3:0] REG_ADDR, // register index
	input wire logic [23:0] REG_WDATA, // write data
	output logic [23:0] REG_RDATA, // read data, next cycle
	input wire logic MCLK_PIN_I, // clock pin level in
	output logic MCLK_PIN_O, // clock pin level out
	output logic MCLK_PIN_OE, // clock pin drive enable
	output logic OSC_EN, // oscillator enabled
	output logic MCLK_EN, // master clock distributed
	output logic MODULATOR_CLOCK_TICK, // modulator clock pulse
	input wire logic RAW_VALID, // raw code strobe
	input wire logic [23:0] RAW_CODE, // raw signed code
	input wire logic RAW_LAST, // last of scan cycle
	output logic CONV_RUN, // converter may convert
	output logic CONV_RESTART, // restart pulse
	output logic DATA_READY, // result ready pulse
	output logic [1:0] CONV_STATE // converter state field
);
	acc_pkg::acc_state_s s, d;
	logic [1:0] clk_sel;
	logic [1:0] mode;
	logic [1:0] conversion_mode_field;
	logic [1:0] presc;
	logic [2:0] pre_lim;
	logic off_en;
	logic gain_en;
	logic full_sd;
	logic osc_tick;
	logic mclk_tick;
	logic pre_tick;
	logic dm_tick;
	logic clk_chg;
	logic accept;
	logic res_wr;
	logic gp_done;
	acc_pkg::acc_wide_t off_sum;

	// saturate the wide value only at the very end
	function automatic logic [23:0] sat(input acc_pkg::acc_wide_t v);
		logic [23:0] r;
		if (v > acc_pkg::RES_MAX) begin
			r = 24'h7FFFFF;
		end else if (v < acc_pkg::RES_MIN) begin
			r = 24'h800000;
		end else begin
			r = v[23:0];
		end
		return r;
	endfunction

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	// held fields read from the registered state
	assign clk_sel = s.cfg0[acc_pkg::CLK_LSB +: 2];
	assign mode = s.cfg0[acc_pkg::MODE_LSB +: 2];
	assign conversion_mode_field = s.cfg3[acc_pkg::CONV_LSB +: 2];
	assign presc = s.cfg1[acc_pkg::PRE_LSB +: 2];
	assign off_en = s.cfg3[acc_pkg::OFFEN_BIT];
	assign gain_en = s.cfg3[acc_pkg::GAINEN_BIT];
	assign full_sd = (s.cfg0 == 8'h00);
	assign pre_lim = 3'((4'h1 << presc) - 4'h1);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = s;
		d.restart = 1'b0;
		d.pend = 1'b0;
		osc_tick = 1'b0;
		pre_tick = 1'b0;
		dm_tick = 1'b0;
		res_wr = 1'b0;
		gp_done = 1'b0;
		// pin passes two flops before the edge detector
		d.ext1 = MCLK_PIN_I;
		d.ext2 = s.ext1;
		d.ext3 = s.ext2;
		// oscillator runs whenever selected, shutdown or not
		if (clk_sel[1]) begin
			if (s.osc_cnt == OSC_DIV - 8'h01) begin
				d.osc_cnt = 8'h00;
				osc_tick = 1'b1;
			end else begin
				d.osc_cnt = s.osc_cnt + 8'h01;
			end
		end
		// source select, gated off in full shutdown
		mclk_tick = !full_sd && (clk_sel[1] ? osc_tick :
			(s.ext2 && !s.ext3));
		// prescaler then fixed divide to the modulator clock
		if (mclk_tick) begin
			if (s.pre_cnt == pre_lim) begin
				d.pre_cnt = 3'h0;
				pre_tick = 1'b1;
			end else begin
				d.pre_cnt = s.pre_cnt + 3'h1;
			end
		end
		if (pre_tick) begin
			d.divided_clock_out = ~s.divided_clock_out;
			if (s.dm_cnt == acc_pkg::DM_DIV_MAX) begin
				d.dm_cnt = 2'h0;
				dm_tick = 1'b1;
			end else begin
				d.dm_cnt = s.dm_cnt + 2'h1;
			end
		end
		d.dm_pulse = dm_tick;
		// register writes from the host side
		clk_chg = REG_WR && REG_ADDR == acc_pkg::ADR_CFG0 &&
			REG_WDATA[acc_pkg::CLK_LSB +: 2] != clk_sel;
		if (REG_WR) begin
			unique case (REG_ADDR)
				acc_pkg::ADR_CFG0: d.cfg0 = REG_WDATA[7:0];
				acc_pkg::ADR_CFG1: d.cfg1 = REG_WDATA[7:0];
				acc_pkg::ADR_CFG3: d.cfg3 = REG_WDATA[7:0];
				acc_pkg::ADR_OFFSET: d.off = REG_WDATA;
				acc_pkg::ADR_GAIN: d.gain = REG_WDATA;
				default: ;
			endcase
		end
		// register reads, unmapped index reads zero
		if (REG_RD) begin
			unique case (REG_ADDR)
				acc_pkg::ADR_RESULT: d.rdata = s.result;
				acc_pkg::ADR_CFG0: d.rdata = {16'h0000, s.cfg0};
				acc_pkg::ADR_CFG1: d.rdata = {16'h0000, s.cfg1};
				acc_pkg::ADR_CFG3: d.rdata = {16'h0000, s.cfg3};
				acc_pkg::ADR_OFFSET: d.rdata = s.off;
				acc_pkg::ADR_GAIN: d.rdata = s.gain;
				default: d.rdata = 24'h000000;
			endcase
		end
		// offset add is combinational; extra bits keep overflow
		off_sum = acc_pkg::acc_wide_t'($signed(RAW_CODE));
		if (off_en) begin
			off_sum = off_sum +
				acc_pkg::acc_wide_t'($signed(s.off));
		end
		// serial multiply, one gain bit per modulator tick
		if (s.gstate == acc_pkg::GP_RUN && dm_tick) begin
			if (s.gmul[s.gidx]) begin
				d.gacc = s.gacc + (s.gx <<< s.gidx);
			end
			if (s.gidx == acc_pkg::GAIN_STEPS) begin
				gp_done = 1'b1;
				d.gstate = acc_pkg::GP_IDLE;
				d.result = sat(d.gacc >>> acc_pkg::GAIN_FRAC);
				res_wr = 1'b1;
			end else begin
				d.gidx = s.gidx + 5'h01;
			end
		end
		// a new raw code takes enables and values as they stand now
		accept = RAW_VALID && s.run;
		if (accept) begin
			if (gain_en) begin
				d.gstate = acc_pkg::GP_RUN;
				d.gmul = s.gain;
				d.gx = off_sum;
				d.gacc = s.gain[0] ? off_sum : '0;
				d.gidx = 5'h01;
			end else begin
				d.result = sat(off_sum);
				res_wr = 1'b1;
			end
			// end of a conversion or scan cycle
			if (RAW_LAST) begin
				unique case (conversion_mode_field)
					2'b00, 2'b01: d.cfg0[acc_pkg::MODE_LSB +: 2] = 2'b00;
					2'b10: d.cfg0[acc_pkg::MODE_LSB +: 2] = 2'b10;
					2'b11: d.cfg0[acc_pkg::MODE_LSB +: 2] = 2'b11;
				endcase
			end
		end
		// setup timer: held at full count while shut down
		if (!d.cfg0[acc_pkg::MODE_LSB + 1]) begin
			d.timer = acc_pkg::SETUP_TICKS;
		end else if (dm_tick && s.timer != 9'h000) begin
			d.timer = s.timer - 9'h001;
		end
		// clock change wipes the conversion and the prescaler and divider phases
		if (clk_chg) begin
			d.timer = acc_pkg::SETUP_TICKS;
			d.gstate = acc_pkg::GP_IDLE;
			d.pre_cnt = 3'h0;
			d.dm_cnt = 2'h0;
			d.divided_clock_out = 1'b0;
			d.restart = 1'b1;
			res_wr = 1'b0;
			d.result = s.result;
		end
		// ready flag trails the stored result by one cycle
		d.pend = res_wr;
		d.drdy = s.pend;
		d.run = d.cfg0[acc_pkg::MODE_LSB +: 2] == 2'b11 &&
			d.timer == 9'h000;
		d.oe = d.cfg0[acc_pkg::CLK_LSB +: 2] == 2'b11;
		d.osc_en = d.cfg0[acc_pkg::CLK_LSB + 1];
		d.mclk_en = d.cfg0 != 8'h00;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// one flop bank; reset puts control at its defaults
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			s <= '0;
			s.cfg0 <= acc_pkg::CFG0_RST;
			s.cfg1 <= acc_pkg::CFG1_RST;
			s.cfg3 <= acc_pkg::CFG3_RST;
			s.gain <= acc_pkg::GAIN_RST;
			s.timer <= acc_pkg::SETUP_TICKS;
			s.mclk_en <= 1'b1; // reset config is not full shutdown
		end else begin
			s <= d;
		end
	end

	// outputs come straight from the state flops
	assign REG_RDATA = s.rdata;
	assign MCLK_PIN_O = s.divided_clock_out;
	assign MCLK_PIN_OE = s.oe;
	assign OSC_EN = s.osc_en;
	assign MCLK_EN = s.mclk_en;
	assign MODULATOR_CLOCK_TICK = s.dm_pulse;
	assign CONV_RUN = s.run;
	assign CONV_RESTART = s.restart;
	assign DATA_READY = s.drdy;
	assign CONV_STATE = mode;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// helper: modulator ticks seen during a multiply
	logic [4:0] gticks_q;
	always_ff @(posedge REF_CLK) begin
		if (RESET || accept) begin
			gticks_q <= 5'h00;
		end else if (s.gstate == acc_pkg::GP_RUN && dm_tick) begin
			gticks_q <= gticks_q + 5'h01;
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);

	sequence s_last(logic [1:0] m);
		accept && RAW_LAST && conversion_mode_field == m && !clk_chg &&
			!(REG_WR && REG_ADDR == acc_pkg::ADR_CFG0);
	endsequence
	sequence s_clk_out;
		REG_WR && REG_ADDR == acc_pkg::ADR_CFG0 &&
			REG_WDATA[acc_pkg::CLK_LSB +: 2] == 2'b11;
	endsequence

	ext_source_a: assert property (!clk_sel[1] && !full_sd && s.ext2 &&
		!s.ext3 |-> mclk_tick)
		else $error("external edge not used as master clock");
	shutdown_gate_a: assert property (full_sd |-> !mclk_tick)
		else $error("master clock ticked in full shutdown");
	clk_restart_a: assert property (clk_chg |=> CONV_RESTART &&
		s.timer == acc_pkg::SETUP_TICKS && s.gstate == acc_pkg::GP_IDLE &&
		s.pre_cnt == 3'h0 && !CONV_RUN)
		else $error("clock change did not restart");
	osc_free_a: assert property (s.cfg0[5] && $past(s.cfg0[5])
		|-> s.osc_cnt != $past(s.osc_cnt))
		else $error("oscillator stalled while selected");
	osc_stop_a: assert property (!s.cfg0[5] |=> $stable(s.osc_cnt))
		else $error("oscillator ran while deselected");
	clock_pin_a: assert property (s_clk_out |=> MCLK_PIN_OE ##0 OSC_EN)
		else $error("clock pin not driven after write");
	offset_path_a: assert property (accept && !gain_en && !clk_chg
		|=> s.result == sat($past(off_sum)) ##1 DATA_READY)
		else $error("offset result wrong or late");
	gain_delay_a: assert property (gp_done && !clk_chg |->
		gticks_q == 5'h16)
		else $error("gain multiply not 23 modulator ticks");
	ready_after_a: assert property (DATA_READY |-> $past(res_wr, 2))
		else $error("data ready without stored result");
	hold_result_a: assert property (REG_WR && !res_wr |=>
		$stable(s.result))
		else $error("register write changed held result");
	oneshot_sd_a: assert property (s_last(2'b00) or s_last(2'b01)
		|=> mode == 2'b00 && !CONV_RUN)
		else $error("one shot did not return to shutdown");
	standby_a: assert property (s_last(2'b10) |=> mode == 2'b10 &&
		!CONV_RUN)
		else $error("one shot did not return to standby");
	continuous_a: assert property (s_last(2'b11) |=> mode == 2'b11)
		else $error("continuous mode left conversion");
	run_timer_a: assert property (CONV_RUN |-> s.timer == 9'h000 &&
		mode == 2'b11)
		else $error("converting before setup done");
endmodule
`default_nettype wire

// [verification/acc_src.sv]
`default_nettype none
// ----------------------------------------
// raw code source and external clock
// ----------------------------------------
module acc_src (
	input wire logic clk, // bench clock
	input wire logic go, // send one raw code
	input wire logic [23:0] code, // code to send
	input wire logic last, // ends a scan cycle
	output logic raw_valid, // strobe to block
	output logic [23:0] raw_code, // code to block
	output logic raw_last, // last flag to block
	output logic mclk_pin // external clock level
);
	timeunit 1ns;
	timeprecision 100ps;
	// free running pin clock, phase unrelated to the bench clock
	initial begin
		mclk_pin = 1'b0;
		forever #15.3 mclk_pin = ~mclk_pin;
	end
	// outside a strobe the code lines show the inverse, so stale data shows
	always @(posedge clk) begin
		raw_valid <= go;
		raw_last <= go & last;
		raw_code <= go ? code : ~code;
	end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic go = 1'b0, last = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [23:0] wdata = 24'h000000, code = 24'h000000, rdata, rcode, rv;
	logic pin_i, pin_o, pin_oe, osc_en, mclk_en, tick, rvalid, rlast;
	logic run, restart, drdy;
	logic [1:0] state;
	int bad_count = 0, n_tests = 0, ticks;
	always #2.5 clk = ~clk;
	acc_ctrl #(.OSC_DIV(8'h02)) acc_ctrl_i (.REF_CLK(clk), .RESET(rst),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .MCLK_PIN_I(pin_i),
		.MCLK_PIN_O(pin_o), .MCLK_PIN_OE(pin_oe), .OSC_EN(osc_en),
		.MCLK_EN(mclk_en), .MODULATOR_CLOCK_TICK(tick), .RAW_VALID(rvalid),
		.RAW_CODE(rcode), .RAW_LAST(rlast), .CONV_RUN(run),
		.CONV_RESTART(restart), .DATA_READY(drdy), .CONV_STATE(state));
	acc_src acc_src_i (.clk(clk), .go(go), .code(code), .last(last),
		.raw_valid(rvalid), .raw_code(rcode), .raw_last(rlast),
		.mclk_pin(pin_i));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// strobe held one cycle, taken at the following edge
	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [23:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1 d = rdata;
	endtask
	task automatic send(input logic [23:0] c, input logic l);
		@(posedge clk);
		go <= 1'b1;
		code <= c;
		last <= l;
		@(posedge clk);
		go <= 1'b0;
	endtask
	// 0 run, 1 ready, 2 restart, 3 pin edge, 4 only count ticks
	task automatic wait_for(input int which, input int lim);
		logic hit;
		logic p0;
		// look first, then wait: a pulse launched at the caller's last
		// edge stands only until the next one
		#1;
		p0 = pin_o;
		ticks = 0;
		for (int i = 0; i < lim; i++) begin
			case (which)
				0: hit = run;
				1: hit = drdy;
				2: hit = restart;
				3: hit = pin_o ^ p0;
				default: hit = 1'b0;
			endcase
			if (hit === 1'b1)
				return;
			ticks += (tick === 1'b1);
			@(posedge clk);
			#1;
		end
		if (which != 4) begin
			bad_count++;
			$display("[FAIL] wait %0d expected 1 seen 0", which);
			summarize();
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		@(posedge clk);
		#1;
		chk("osc_en", 24'h0, osc_en);
		chk("pin_oe", 24'h0, pin_oe);
		rd(acc_pkg::ADR_CFG0, rv);
		chk("cfg0", {16'h0, acc_pkg::CFG0_RST}, rv);
		rd(acc_pkg::ADR_GAIN, rv);
		chk("gain", acc_pkg::GAIN_RST, rv);
		rd(4'h3, rv);
		chk("unmapped", 24'h0, rv);
	endtask
	// each clock source in turn, ending in full shutdown
	task automatic t_clock();
		logic [7:0] sel [4] = '{8'h10, 8'h20, 8'h30, 8'h00};
		logic [3:0] ex [4] = '{4'hC, 4'hD, 4'hF, 4'h0};
		for (int i = 0; i < 4; i++) begin
			wr(acc_pkg::ADR_CFG0, {16'h0, sel[i]});
			wait_for(2, 4);
			// let a modulator pulse launched before the change pass
			wait_for(4, 1);
			wait_for(4, 64);
			chk("osc_en", ex[i][0], osc_en);
			chk("pin_oe", ex[i][1], pin_oe);
			chk("mclk_en", ex[i][2], mclk_en);
			chk("ticks", ex[i][3], ticks != 0);
			if (i == 2)
				wait_for(3, 16);
		end
	endtask
	// offset set but disabled must not reach the result
	task automatic t_conv();
		wr(acc_pkg::ADR_OFFSET, 24'h000123);
		wr(acc_pkg::ADR_CFG3, 24'h0000C0);
		wr(acc_pkg::ADR_CFG0, 24'h000033);
		wait_for(0, 3000);
		chk("setup", 24'h1, ticks >= 255 && ticks <= 258);
		send(24'h000100, 1'b0);
		wait_for(1, 4);
		rd(acc_pkg::ADR_RESULT, rv);
		chk("result", 24'h000100, rv);
		chk("state", 24'h3, state);
	endtask
	task automatic t_offset();
		wr(acc_pkg::ADR_OFFSET, 24'hFFFF00);
		wr(acc_pkg::ADR_CFG3, 24'h0000C2);
		rd(acc_pkg::ADR_RESULT, rv);
		chk("held", 24'h000100, rv);
		send(24'h000050, 1'b0);
		wait_for(1, 4);
		rd(acc_pkg::ADR_RESULT, rv);
		chk("offset sum", 24'hFFFF50, rv);
	endtask
	// the sum overflows 24 bits; halving brings it back, a gain just under unity saturates
	task automatic t_gain();
		logic [23:0] gv [2] = '{24'h400000, 24'h7FFFFF};
		logic [23:0] ev [2] = '{24'h47FFF8, 24'h7FFFFF};
		wr(acc_pkg::ADR_OFFSET, 24'h100000);
		wr(acc_pkg::ADR_CFG3, 24'h0000C3);
		for (int i = 0; i < 2; i++) begin
			wr(acc_pkg::ADR_GAIN, gv[i]);
			rd(acc_pkg::ADR_RESULT, rv);
			chk("held", i ? ev[0] : 24'hFFFF50, rv);
			send(24'h7FFFF0, 1'b0);
			wait_for(1, 400);
			chk("delay", 24'h1, ticks >= 22 && ticks <= 24);
			rd(acc_pkg::ADR_RESULT, rv);
			chk("corrected", ev[i], rv);
		end
	endtask
	task automatic t_oneshot();
		logic [1:0] md [2] = '{2'b00, 2'b10};
		for (int i = 0; i < 2; i++) begin
			wr(acc_pkg::ADR_CFG3, {16'h0, md[i], 6'h00});
			wr(acc_pkg::ADR_CFG0, 24'h000033);
			wait_for(0, 3000);
			send(24'h000010, 1'b1);
			wait_for(1, 4);
			wait_for(4, 4);
			chk("state", md[i], state);
		end
		// in standby a code offered while not converting is dropped
		chk("run", 24'h0, run);
		send(24'h000777, 1'b0);
		wait_for(4, 8);
		rd(acc_pkg::ADR_RESULT, rv);
		chk("refused", 24'h000010, rv);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_clock();
		t_conv();
		t_offset();
		t_gain();
		t_oneshot();
		summarize();
	end
endmodule
`default_nettype wire
